/* File: sli_pkg.sv */
// Shared constants of the front-panel indicator block.
// Assumes a single 20 MHz clock and a word-wide register port.
package sli_pkg;
  // ----------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------
  localparam int CLK_HZ   = 20_000_000; // System clock rate
  localparam int TICK_MS  = 10;         // Blink time base in ms
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS; // Cycles per tick

  // Half periods and pulse lengths in ms, then in ticks
  localparam int RAPID_HALF_MS = 167;   // About three flashes a second
  localparam int SLOW_HALF_MS  = 500;   // One flash a second
  localparam int ACT_HALF_MS   = 50;    // Activity flicker
  localparam int PULSE_MS      = 150;   // Burst pulse, on and off
  localparam int PAUSE_MS      = 1000;  // Dark gap after a burst
  localparam logic [7:0] RAPID_TICKS = 8'(RAPID_HALF_MS / TICK_MS);
  localparam logic [7:0] SLOW_TICKS  = 8'(SLOW_HALF_MS / TICK_MS);
  localparam logic [7:0] ACT_TICKS   = 8'(ACT_HALF_MS / TICK_MS);
  localparam logic [7:0] PULSE_TICKS = 8'(PULSE_MS / TICK_MS);
  localparam logic [7:0] PAUSE_TICKS = 8'(PAUSE_MS / TICK_MS);

  // Blinker channels and their half periods
  localparam int BL_RAPID = 0;
  localparam int BL_SLOW  = 1;
  localparam int BL_ACT   = 2;
  localparam logic [2:0][7:0] BLINK_HALF =
    {ACT_TICKS, SLOW_TICKS, RAPID_TICKS};

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00; // Control
  localparam logic [7:0] ADDR_STS  = 8'h04; // Sticky status, W1C
  localparam logic [7:0] ADDR_MASK = 8'h08; // Interrupt mask
  localparam logic [7:0] ADDR_LIVE = 8'h0c; // Live conditions
  localparam logic [7:0] ADDR_RT   = 8'h10; // Run time in ticks
  localparam logic [7:0] ADDR_LCNT = 8'h14; // Fault log fill
  localparam logic [7:0] ADDR_LOG0 = 8'h18; // Newest fault entry
  localparam int         LOG_DEPTH = 5;     // Entries kept

  // Field positions and reset values
  localparam int CTRL_CONF_EN = 0;          // Conflict detect enable
  localparam logic CTRL_RST   = 1'b0;
  localparam int ST_FMT  = 0;               // Data format error
  localparam int ST_HS   = 1;               // Handshake violation
  localparam int ST_CONF = 2;               // Address conflict
  localparam int ST_FAIL = 3;               // Self-test failure
  localparam logic [3:0] MASK_RST = 4'h0;

  // Fault log entry: code in the top nibble, run time below
  localparam int LOG_TIME_W = 28;
  localparam logic [3:0] FC_PARITY  = 4'h1;
  localparam logic [3:0] FC_FRAME   = 4'h2;
  localparam logic [3:0] FC_OVERRUN = 4'h3;
  localparam logic [3:0] FC_HSHAKE  = 4'h4;

  // Synchronised input vector positions
  localparam int NIN       = 15;
  localparam int IN_PEXT   = 0;
  localparam int IN_PPOE   = 1;
  localparam int IN_BOOT   = 2;
  localparam int IN_ADDR   = 3;
  localparam int IN_CONN   = 4;
  localparam int IN_CONF   = 5;
  localparam int IN_PAR    = 6;
  localparam int IN_FRM    = 7;
  localparam int IN_OVR    = 8;
  localparam int IN_HS     = 9;
  localparam int IN_STDONE = 10;
  localparam int IN_STOK   = 11;
  localparam int IN_LINK   = 12;
  localparam int IN_S100   = 13;
  localparam int IN_ACT    = 14;

  // Burst generator states
  typedef enum logic [1:0] {P_IDLE, P_ON, P_OFF, P_PAUSE} sli_burst_t;
endpackage

/* File: sli_burst.sv */
// Error lamp burst generator: n short pulses, then a long dark gap.
// Assumes a one-cycle tick enable from the owner's divider.
`timescale 1ns/1ps
module sli_burst
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       tick,  // Time base enable
  input  wire logic [1:0] count, // Pulses per burst, 0 = dark
  output logic            led    // Lamp drive
);
  sli_pkg::sli_burst_t state_reg;  // Burst phase
  sli_pkg::sli_burst_t state_next;
  logic [7:0]          tcnt_reg;   // Ticks in phase
  logic [7:0]          tcnt_next;
  logic [1:0]          pcnt_reg;   // Pulse number
  logic [1:0]          pcnt_next;
  // Length taken at burst start, so a burst never changes size midway
  logic [1:0]          want_reg;   // Pulses in this burst
  logic [1:0]          want_next;

  // ----------------------------------------------------------------
  // Phase sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    tcnt_next  = tcnt_reg;
    pcnt_next  = pcnt_reg;
    want_next  = want_reg;
    unique case (state_reg)
      sli_pkg::P_IDLE:
      begin
        tcnt_next = 8'h00;
        pcnt_next = 2'h1;
        want_next = count;
        if (count != 2'h0)
          state_next = sli_pkg::P_ON;
      end
      sli_pkg::P_ON:
        if (tick)
        begin
          if (tcnt_reg == sli_pkg::PULSE_TICKS - 8'h01)
          begin
            tcnt_next  = 8'h00;
            state_next = sli_pkg::P_OFF;
          end
          else
            tcnt_next = tcnt_reg + 8'h01;
        end
      sli_pkg::P_OFF:
        if (tick)
        begin
          if (tcnt_reg == sli_pkg::PULSE_TICKS - 8'h01)
          begin
            tcnt_next = 8'h00;
            // Last pulse of the burst leads to the long gap
            if (pcnt_reg >= want_reg)
              state_next = sli_pkg::P_PAUSE;
            else
            begin
              pcnt_next  = pcnt_reg + 2'h1;
              state_next = sli_pkg::P_ON;
            end
          end
          else
            tcnt_next = tcnt_reg + 8'h01;
        end
      sli_pkg::P_PAUSE:
        if (tick)
        begin
          if (tcnt_reg == sli_pkg::PAUSE_TICKS - 8'h01)
            state_next = sli_pkg::P_IDLE;
          else
            tcnt_next = tcnt_reg + 8'h01;
        end
    endcase
    // Pattern withdrawn: go dark at once
    if (count == 2'h0)
      state_next = sli_pkg::P_IDLE;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_reg <= sli_pkg::P_IDLE;
      tcnt_reg  <= 8'h00;
      pcnt_reg  <= 2'h1;
      want_reg  <= 2'h0;
    end
    else
    begin
      state_reg <= state_next;
      tcnt_reg  <= tcnt_next;
      pcnt_reg  <= pcnt_next;
      want_reg  <= want_next;
    end
  end

  assign led = (state_reg == sli_pkg::P_ON);

  // Gap is dark and never holds more pulses than asked
  pause_dark_a: assert property (@(posedge clk) disable iff (srst)
    (state_reg == sli_pkg::P_PAUSE) |-> (!led && pcnt_reg == want_reg))
    else $error("burst gap lit or wrong pulse count");
endmodule

/* File: sli_flog.sv */
// Log of the newest serial faults, newest first, shift on write.
// Assumes at most one write per cycle from the owner.
`timescale 1ns/1ps
module sli_flog
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        wr_en,   // Store one entry
  input  wire logic [31:0] wr_data, // Code and time stamp
  input  wire logic [2:0]  rd_idx,  // Entry, 0 = newest
  output logic      [31:0] rd_data, // Entry or zero
  output logic      [2:0]  fill     // Entries held
);
  localparam int D = sli_pkg::LOG_DEPTH;
  logic [31:0] mem_reg [D];  // Entry store
  logic [2:0]  fill_reg;     // Entry count
  logic [2:0]  fill_next;

  // ----------------------------------------------------------------
  // Shift store: oldest entry falls off the end
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < D; g++)
    begin : g_ent
      always_ff @(posedge clk)
      begin
        if (srst)
          mem_reg[g] <= 32'h0;
        else if (wr_en)
          mem_reg[g] <= (g == 0) ? wr_data : mem_reg[(g == 0) ? 0 : g - 1];
      end
    end
  endgenerate

  // Fill count saturates at the depth
  always_comb
  begin
    fill_next = fill_reg;
    if (wr_en && fill_reg != 3'(D))
      fill_next = fill_reg + 3'h1;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      fill_reg <= 3'h0;
    else
      fill_reg <= fill_next;
  end

  assign fill    = fill_reg;
  assign rd_data = (rd_idx < fill_reg) ? mem_reg[rd_idx] : 32'h0;

  log_fill_a: assert property (@(posedge clk) disable iff (srst)
    wr_en |=> (fill_reg == ($past(fill_reg) == 3'(D) ? 3'(D)
                                                     : $past(fill_reg) + 3'h1))
              && mem_reg[0] == $past(wr_data))
    else $error("fault log did not take the entry");
endmodule

/* File: sli_top.sv */
// Front-panel lamp logic of a serial device server: power, status,
// error, speed and link lamps, sticky event status and a fault log.
// Assumes all condition inputs may come from other domains and pins.
`timescale 1ns/1ps
module sli_top
#(
  parameter int unsigned TICK_CYC = sli_pkg::TICK_CYC // Cycles per tick
)
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        pwr_ext,       // Terminal supply present
  input  wire logic        pwr_poe,       // Cable supply present
  input  wire logic        booting,       // Boot phase
  input  wire logic        addr_valid,    // Network address assigned
  input  wire logic        conn_valid,    // Port connection open
  input  wire logic        addr_conflict, // Address seen elsewhere
  input  wire logic        rx_parity_err,
  input  wire logic        rx_frame_err,
  input  wire logic        rx_overrun,
  input  wire logic        hs_violation,  // Sending past stop
  input  wire logic        selftest_done,
  input  wire logic        selftest_ok,
  input  wire logic        phy_link,
  input  wire logic        phy_speed100,
  input  wire logic        phy_activity,
  output logic             led_power,
  output logic             led_status,
  output logic             led_error,
  output logic             led_speed,
  output logic             led_link,
  output logic             irq
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [sli_pkg::NIN-1:0] s1_reg;      // First sync stage only
  logic [sli_pkg::NIN-1:0] s2_reg;      // Safe copies
  logic [sli_pkg::NIN-1:0] s3_reg;      // Edge reference
  logic [sli_pkg::NIN-1:0] rise;        // Rising edges
  logic [17:0]             tdiv_reg;    // Tick divider
  logic [17:0]             tdiv_next;
  logic                    tick_reg;    // One-cycle tick
  logic                    tick_next;
  logic [2:0][7:0]         bc_reg;      // Blinker counters
  logic [2:0][7:0]         bc_next;
  logic [2:0]              ph_reg;      // Blinker phases
  logic [2:0]              ph_next;
  logic [7:0]              act_reg;     // Recent-traffic hold
  logic [7:0]              act_next;
  logic [27:0]             rt_reg;      // Run time in ticks
  logic [27:0]             rt_next;
  logic                    fail_reg;    // Self-test failed
  logic                    fail_next;
  logic                    ctrl_reg;    // Conflict detect enable
  logic                    ctrl_next;
  logic [3:0]              sts_reg;     // Sticky event status
  logic [3:0]              sts_next;
  logic [3:0]              mask_reg;    // Interrupt mask
  logic [3:0]              mask_next;
  logic [31:0]             rdata_reg;   // Read answer
  logic [31:0]             rdata_next;
  logic [5:0]              led_reg;     // Lamp and irq flops
  logic [5:0]              led_next;
  logic [1:0]              err_cnt;     // Burst length requested
  logic                    burst_led;
  logic                    conf_act;    // Enabled conflict live
  logic                    log_wr;
  logic [3:0]              log_code;
  logic [31:0]             log_rd;
  logic [2:0]              log_fill;
  logic [2:0]              log_idx;
  logic [3:0]              w1c;

  // ----------------------------------------------------------------
  // Input synchronisers; edges compare the second and third stages
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end
    else
    begin
      s1_reg <= {phy_activity, phy_speed100, phy_link, selftest_ok,
                 selftest_done, hs_violation, rx_overrun, rx_frame_err,
                 rx_parity_err, addr_conflict, conn_valid, addr_valid,
                 booting, pwr_poe, pwr_ext};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  assign rise = s2_reg & ~s3_reg;

  // ----------------------------------------------------------------
  // Time base, blinkers, run time
  // ----------------------------------------------------------------
  always_comb
  begin
    tick_next = (tdiv_reg == 18'(TICK_CYC - 1));
    tdiv_next = tick_next ? 18'h0 : tdiv_reg + 18'h1;
    rt_next   = tick_reg ? rt_reg + 28'h1 : rt_reg;
    // Traffic keeps the flicker alive for two half periods
    if (s2_reg[sli_pkg::IN_ACT])
      act_next = {sli_pkg::ACT_TICKS[6:0], 1'b0};
    else if (tick_reg && act_reg != 8'h0)
      act_next = act_reg - 8'h01;
    else
      act_next = act_reg;
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_blink
      // Each channel toggles its phase every half period
      always_comb
      begin
        bc_next[g] = bc_reg[g];
        ph_next[g] = ph_reg[g];
        if (tick_reg)
        begin
          if (bc_reg[g] == sli_pkg::BLINK_HALF[g] - 8'h01)
          begin
            bc_next[g] = 8'h00;
            ph_next[g] = ~ph_reg[g];
          end
          else
            bc_next[g] = bc_reg[g] + 8'h01;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      tdiv_reg <= 18'h0;
      tick_reg <= 1'b0;
      bc_reg   <= '0;
      ph_reg   <= 3'h0;
      act_reg  <= 8'h00;
      rt_reg   <= 28'h0;
    end
    else
    begin
      tdiv_reg <= tdiv_next;
      tick_reg <= tick_next;
      bc_reg   <= bc_next;
      ph_reg   <= ph_next;
      act_reg  <= act_next;
      rt_reg   <= rt_next;
    end
  end

  // ----------------------------------------------------------------
  // Fault capture and logging
  // ----------------------------------------------------------------
  // One code per cycle; coincident faults keep the worst one only,
  // a trade for a single-port log.
  always_comb
  begin
    log_code = 4'h0;
    if (rise[sli_pkg::IN_HS])
      log_code = sli_pkg::FC_HSHAKE;
    else if (rise[sli_pkg::IN_OVR])
      log_code = sli_pkg::FC_OVERRUN;
    else if (rise[sli_pkg::IN_FRM])
      log_code = sli_pkg::FC_FRAME;
    else if (rise[sli_pkg::IN_PAR])
      log_code = sli_pkg::FC_PARITY;
  end
  // Logging stops once the unit is out of service
  assign log_wr  = (log_code != 4'h0) && !fail_reg;
  assign log_idx = 3'((reg_addr - sli_pkg::ADDR_LOG0) >> 2);

  sli_flog u_flog
  (
    .clk     (clk),
    .srst    (srst),
    .wr_en   (log_wr),
    .wr_data ({log_code, rt_reg}),
    .rd_idx  (log_idx),
    .rd_data (log_rd),
    .fill    (log_fill)
  );

  // ----------------------------------------------------------------
  // Registers: control, sticky status, mask, read answer
  // ----------------------------------------------------------------
  always_comb
  begin
    conf_act  = ctrl_reg && s2_reg[sli_pkg::IN_CONF];
    // Failure is caught once the test reports done without success
    fail_next = fail_reg ||
                (s2_reg[sli_pkg::IN_STDONE] && !s2_reg[sli_pkg::IN_STOK]);
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    w1c       = 4'h0;
    if (reg_wr && reg_addr == sli_pkg::ADDR_CTRL)
      ctrl_next = reg_wdata[sli_pkg::CTRL_CONF_EN];
    if (reg_wr && reg_addr == sli_pkg::ADDR_MASK)
      mask_next = reg_wdata[3:0];
    if (reg_wr && reg_addr == sli_pkg::ADDR_STS)
      w1c = reg_wdata[3:0];
    // Clear first, then set, so a new event is never lost to a clear
    sts_next = sts_reg & ~w1c;
    if (!fail_reg)
    begin
      if (|rise[sli_pkg::IN_OVR:sli_pkg::IN_PAR])
        sts_next[sli_pkg::ST_FMT] = 1'b1;
      if (rise[sli_pkg::IN_HS])
        sts_next[sli_pkg::ST_HS] = 1'b1;
      if (conf_act)
        sts_next[sli_pkg::ST_CONF] = 1'b1;
    end
    if (fail_reg)
      sts_next[sli_pkg::ST_FAIL] = 1'b1;
    rdata_next = 32'h0;
    if (reg_rd)
    begin
      unique case (reg_addr)
        sli_pkg::ADDR_CTRL: rdata_next = {31'h0, ctrl_reg};
        sli_pkg::ADDR_STS:  rdata_next = {28'h0, sts_reg};
        sli_pkg::ADDR_MASK: rdata_next = {28'h0, mask_reg};
        sli_pkg::ADDR_LIVE: rdata_next = {17'h0, fail_reg, s2_reg[13:0]};
        sli_pkg::ADDR_RT:   rdata_next = {4'h0, rt_reg};
        sli_pkg::ADDR_LCNT: rdata_next = {29'h0, log_fill};
        8'h18, 8'h1c, 8'h20, 8'h24, 8'h28:
          rdata_next = log_rd;
        default:            rdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      fail_reg  <= 1'b0;
      ctrl_reg  <= sli_pkg::CTRL_RST;
      sts_reg   <= 4'h0;
      mask_reg  <= sli_pkg::MASK_RST;
      rdata_reg <= 32'h0;
    end
    else
    begin
      fail_reg  <= fail_next;
      ctrl_reg  <= ctrl_next;
      sts_reg   <= sts_next;
      mask_reg  <= mask_next;
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Lamp selection
  // ----------------------------------------------------------------
  // Handshake outranks format in the burst length
  assign err_cnt = sts_reg[sli_pkg::ST_HS]  ? 2'h3 :
                   sts_reg[sli_pkg::ST_FMT] ? 2'h2 : 2'h0;

  sli_burst u_burst
  (
    .clk   (clk),
    .srst  (srst),
    .tick  (tick_reg),
    .count (err_cnt),
    .led   (burst_led)
  );

  // Order in led_reg: irq, link, speed, error, status, power
  always_comb
  begin
    led_next[0] = s2_reg[sli_pkg::IN_PEXT] | s2_reg[sli_pkg::IN_PPOE];
    if (s2_reg[sli_pkg::IN_BOOT] || !s2_reg[sli_pkg::IN_ADDR])
      led_next[1] = ph_reg[sli_pkg::BL_RAPID];
    else if (s2_reg[sli_pkg::IN_CONN])
      led_next[1] = ph_reg[sli_pkg::BL_SLOW];
    else
      led_next[1] = 1'b0;
    if (conf_act)
      led_next[2] = ph_reg[sli_pkg::BL_RAPID];
    else
      led_next[2] = burst_led;
    led_next[3] = s2_reg[sli_pkg::IN_LINK] &
                  s2_reg[sli_pkg::IN_S100];
    if (!s2_reg[sli_pkg::IN_LINK])
      led_next[4] = 1'b0;
    else if (act_reg != 8'h0)
      led_next[4] = ph_reg[sli_pkg::BL_ACT];
    else
      led_next[4] = 1'b1;
    led_next[5] = |(sts_next & mask_reg);
    // Failed self-test overrides every lamp
    if (fail_reg)
      led_next[4:0] = 5'h1f;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      led_reg <= 6'h00;
    else
      led_reg <= led_next;
  end

  assign led_power  = led_reg[0];
  assign led_status = led_reg[1];
  assign led_error  = led_reg[2];
  assign led_speed  = led_reg[3];
  assign led_link   = led_reg[4];
  assign irq        = led_reg[5];
  assign reg_rdata  = rdata_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  power_lamp_a: assert property (@(posedge clk) disable iff (srst)
    (s2_reg[sli_pkg::IN_PEXT] || s2_reg[sli_pkg::IN_PPOE]) |=> led_power)
    else $error("power lamp dark with supply present");

  test_fail_a: assert property (@(posedge clk) disable iff (srst)
    fail_reg |=> (led_power && led_status && led_error && led_speed
                  && led_link) [*2])
    else $error("self-test failure not shown on all lamps");

  link_off_a: assert property (@(posedge clk) disable iff (srst)
    (!s2_reg[sli_pkg::IN_LINK] && !fail_reg) |=> !led_link && !led_speed)
    else $error("link lamps lit without link");

  link_on_a: assert property (@(posedge clk) disable iff (srst)
    (s2_reg[sli_pkg::IN_LINK] && act_reg == 8'h0 && !fail_reg) |=> led_link)
    else $error("link lamp dark with idle link");

  fmt_latch_a: assert property (@(posedge clk) disable iff (srst)
    (rise[sli_pkg::IN_PAR] && !fail_reg) |=> sts_reg[sli_pkg::ST_FMT]
      ##1 (sts_reg[sli_pkg::ST_FMT] || $past(w1c[sli_pkg::ST_FMT])))
    else $error("format error not latched");

  err_prio_a: assert property (@(posedge clk) disable iff (srst)
    sts_reg[sli_pkg::ST_HS] |-> err_cnt == 2'h3)
    else $error("handshake pattern not preferred");

  irq_level_a: assert property (@(posedge clk) disable iff (srst)
    (|(sts_reg & mask_reg)) |-> ##[0:1] irq)
    else $error("interrupt missing for masked-in status");

  mask_read_a: assert property (@(posedge clk) disable iff (srst)
    (reg_rd && reg_addr == sli_pkg::ADDR_MASK)
      |=> reg_rdata == {28'h0, $past(mask_reg)} ##1 reg_rdata == 32'h0
        || $past(reg_rd))
    else $error("mask read answer wrong");
endmodule

/* File: sli_eye.sv */
// Operator model: counts how often each front lamp lights.
// Assumes lamps are sampled on clk; clr restarts every count.
`timescale 1ns/1ps
module sli_eye
(
  input  wire logic       clk,
  input  wire logic       clr,
  input  wire logic [4:0] lamp,
  output int              lit [5]
);
  logic [4:0] last_reg; // Lamp state one cycle back
  // Count dark-to-lit changes; a lamp held on counts once
  always_ff @(posedge clk)
  begin
    last_reg <= lamp;
    for (int i = 0; i < 5; i++)
      lit[i] <= clr ? 0 : lit[i] + int'(lamp[i] & ~last_reg[i]);
  end
endmodule

/* File: testbench.sv */
// Bench for the lamp block: a table of steady cases, then flashes.
// Assumes a 4-cycle tick so every flash period stays short.
`timescale 1ns/1ps
module testbench;
  logic        clk = 0;
  logic        srst = 1;
  logic        reg_wr = 0;
  logic        reg_rd = 0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic [14:0] cond = 15'h0c09; // Inputs in package order
  logic [4:0]  lamp;            // Link, speed, error, status, power
  logic        irq;
  logic        clr = 0;
  int          lit [5];         // Lamp lightings seen
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          cyc = 0;
  // Supplies, link, speed beside power, speed, link lamps
  logic [6:0]  rows [4] = '{7'h44, 7'h3f, 7'h75, 7'h00};

  sli_top #(.TICK_CYC(4)) dut
  (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pwr_ext(cond[0]), .pwr_poe(cond[1]), .booting(cond[2]),
    .addr_valid(cond[3]), .conn_valid(cond[4]), .addr_conflict(cond[5]),
    .rx_parity_err(cond[6]), .rx_frame_err(cond[7]),
    .rx_overrun(cond[8]), .hs_violation(cond[9]),
    .selftest_done(cond[10]), .selftest_ok(cond[11]),
    .phy_link(cond[12]), .phy_speed100(cond[13]),
    .phy_activity(cond[14]), .led_power(lamp[0]), .led_status(lamp[1]),
    .led_error(lamp[2]), .led_speed(lamp[3]), .led_link(lamp[4]),
    .irq(irq)
  );
  sli_eye eye (.clk(clk), .clr(clr), .lamp(lamp), .lit(lit));

  initial
    forever #25 clk = ~clk;
  // Hang guard; the whole run needs under 10000 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      conclude;
    end
  end

  task automatic conclude;
    if (n_mismatch == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task automatic cnt(input int i, input int lo, input int hi);
    n_compared++;
    if (lit[i] < lo || lit[i] > hi)
    begin
      n_mismatch++;
      $display("wrong value at %0t: lamp %0d lit %0d", $time, i, lit[i]);
    end
  endtask
  task automatic go(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic see(input int n);
    clr <= 1;
    go(1);
    clr <= 0;
    go(n);
  endtask
  task automatic ev(input int i);
    cond[i] <= 1;
    go(3);
    cond[i] <= 0;
    go(3);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
    @(posedge clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 0;
    #1 cmp(reg_rdata & m, e);
  endtask

  initial
  begin
    go(12);
    cmp(lamp, 5'h00);
    srst <= 0;
    foreach (rows[k])
    begin
      {cond[0], cond[1], cond[12], cond[13]} <= rows[k][6:3];
      go(5);
      cmp({lamp[0], lamp[3], lamp[4]}, rows[k][2:0]);
    end
    cond[2] <= 1;
    see(640);
    cnt(1, 4, 6);
    cond[2] <= 0;
    cond[4] <= 1;
    see(800);
    cnt(1, 1, 3);
    wr(sli_pkg::ADDR_CTRL, 32'h1);
    rd(sli_pkg::ADDR_CTRL, 32'hffffffff, 32'h1);
    cond[5] <= 1;
    see(640);
    cnt(2, 4, 6);
    wr(sli_pkg::ADDR_CTRL, 32'h0);
    see(300);
    cnt(2, 0, 0);
    cond[5] <= 0;
    wr(sli_pkg::ADDR_STS, 32'h4);
    ev(6);
    see(1280);
    cnt(2, 3, 5);
    rd(sli_pkg::ADDR_STS, 32'hf, 32'h1);
    rd(sli_pkg::ADDR_LOG0, 32'hf0000000, 32'h10000000);
    wr(sli_pkg::ADDR_MASK, 32'h1);
    go(2);
    cmp(irq, 1'b1);
    rd(sli_pkg::ADDR_MASK, 32'hffffffff, 32'h1);
    wr(sli_pkg::ADDR_MASK, 32'h0);
    go(2);
    cmp(irq, 1'b0);
    // Both faults at once from a dark lamp: the longer burst must win
    wr(sli_pkg::ADDR_STS, 32'h1);
    cond[6] <= 1;
    ev(9);
    cond[6] <= 0;
    see(1280);
    cnt(2, 5, 7);
    wr(sli_pkg::ADDR_STS, 32'h3);
    see(700);
    cnt(2, 0, 0);
    repeat (4) ev(7);
    rd(sli_pkg::ADDR_LCNT, 32'hffffffff, 32'h5);
    rd(8'h28, 32'hf0000000, 32'h40000000);
    rd(8'h30, 32'hffffffff, 32'h0);
    cond[12] <= 1;
    cond[14] <= 1;
    see(200);
    cnt(4, 3, 6);
    cond[11] <= 0;
    go(5);
    cmp(lamp, 5'h1f);
    rd(sli_pkg::ADDR_LIVE, 32'hffffffff, 32'h00005418);
    conclude;
  end
endmodule
